// File: bench/page_attribute_memory_typing_bench.sv
// Bench for the page typing block: table access, faults, indexing, combining.
// Assumes the walker model drives the translation inputs.
`timescale 1ns/100ps
module page_attribute_memory_typing_bench;
   import attr_pkg::*;
   localparam logic [63:0] TBL2 = 64'h0006_0604_0501_0700;
   logic         core_clk_in = 1'b0;
   logic         arst_n_in   = 1'b0;
   logic         wr_valid    = 1'b0;
   logic         rd_valid    = 1'b0;
   logic [63:0]  wr_data     = '0;
   logic         xv, ren, wdone, flt, fres, rdone, tv;
   logic [63:0]  ent, rdata, tbl;
   logic [51:0]  paddr, taddr;
   logic [7:0]   fslots;
   wire  [7:0]   flags;
   logic [2:0]   idx;
   entry_kind_e  kind;
   mem_type_e    rtype, st, et;
   int           errors = 0;
   int           checks = 0;
   mem_type_e    rl[5] = '{uncacheable, write_combining, write_protect, writethrough_type, writeback};

   initial forever #12.5 core_clk_in = ~core_clk_in;

   walker_model #(.ENTRY_W(64), .ADDR_W(52)) walker (
      .clk_in(core_clk_in), .valid_out(xv), .entry_out(ent), .kind_out(kind),
      .addr_out(paddr), .range_type_out(rtype), .range_enable_out(ren));

   page_attribute_memory_typing #(.ENTRY_W(64), .ADDR_W(52)) dut (
      .core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
      .wr_valid_in(wr_valid), .wr_data_in(wr_data), .rd_valid_in(rd_valid),
      .wr_done_out(wdone), .fault_out(flt), .fault_reserved_out(fres),
      .fault_slots_out(fslots), .rd_done_out(rdone), .rd_data_out(rdata),
      .xlate_valid_in(xv), .entry_in(ent), .kind_in(kind), .phys_addr_in(paddr),
      .range_type_in(rtype), .range_enable_in(ren),
      .typed_valid_out(tv), .typed_addr_out(taddr), .slot_index_out(idx),
      .slot_type_out(st), .eff_type_out(et),
      .read_alloc_out(flags[7]), .read_excl_ok_out(flags[6]), .write_alloc_out(flags[5]),
      .write_to_memory_out(flags[4]), .write_hit_update_out(flags[3]),
      .write_hit_inval_out(flags[2]), .combine_ok_out(flags[1]), .spec_ok_out(flags[0]));

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task close_out;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic acc(input logic w, input logic r, input logic [63:0] d);
      @(posedge core_clk_in);
      wr_valid <= w;
      rd_valid <= r;
      wr_data <= d;
      @(posedge core_clk_in);
      wr_valid <= 1'b0;
      rd_valid <= 1'b0;
      #1;
   endtask

   task automatic wr_chk(input logic [63:0] d, input logic [10:0] exp);
      acc(1'b1, 1'b0, d);
      chk({wdone, flt, fres, fslots}, exp);
   endtask

   function automatic mem_type_e eff(mem_type_e p, mem_type_e r);
      if (p == write_combining) return write_combining;
      if (r == uncacheable) return uncacheable;
      case (p)
         uncacheable_minus: return (r == write_combining) ? write_combining : cache_disabled_effective;
         write_protect: return (r inside {write_protect, writeback}) ? write_protect : cache_disabled_effective;
         writethrough_type: return (r inside {writethrough_type, writeback}) ? writethrough_type
                                                                             : cache_disabled_effective;
         writeback: return r;
         default: return cache_disabled_effective;
      endcase
   endfunction

   // Flags: read alloc, excl, write alloc, to memory, hit update, hit inval, combine, spec
   function automatic logic [7:0] pol(mem_type_e t);
      case (t)
         write_combining: return 8'h13;
         writethrough_type: return 8'h99;
         write_protect: return 8'h95;
         writeback: return 8'he9;
         default: return 8'h10;
      endcase
   endfunction

   function automatic logic [63:0] ent_of(logic [2:0] i);
      return {56'h0, i[2], 2'b00, i[1], i[0], 3'b000};
   endfunction

   task automatic xl(input logic [63:0] e, input entry_kind_e k, input mem_type_e r, input logic en,
                     input logic [2:0] i);
      mem_type_e p;
      mem_type_e x;
      p = mem_type_e'(tbl[8*i +: 3]);
      x = eff(p, en ? r : uncacheable);
      walker.req(e, k, r, en);
      chk({tv, idx}, {1'b1, i});
      chk({taddr, st}, {walker.sent, p});
      chk(et, x);
      chk(flags, pol(x));
   endtask

   task automatic sweep;
      for (int i = 0; i < 8; i++) begin
         xl(ent_of(i[2:0]), leaf_entry, writeback, 1'b1, i[2:0]);
      end
   endtask

   initial begin
      repeat (4) @(posedge core_clk_in);
      arst_n_in <= 1'b1;
      tbl = TABLE_RESET;
      acc(1'b0, 1'b1, '0);
      chk(rdata, TABLE_RESET);
      sweep();
      // Read alongside a write still sees the old table
      acc(1'b1, 1'b1, TBL2);
      chk({wdone, flt, rdone}, 3'b101);
      chk(rdata, TABLE_RESET);
      tbl = TBL2;
      wr_chk(TBL2 | 64'h80, 11'h701);
      wr_chk(64'h0006_0304_0501_0700, 11'h620);
      acc(1'b0, 1'b1, '0);
      chk(rdata, TBL2);
      sweep();
      for (int s = 0; s < 6; s++) begin
         for (int j = 0; j < 5; j++) begin
            xl(ent_of(s[2:0]), leaf_entry, rl[j], 1'b1, s[2:0]);
         end
         xl(ent_of(s[2:0]), leaf_entry, writeback, 1'b0, s[2:0]);
      end
      xl(64'h1008, large_directory, writeback, 1'b1, 3'd5);
      xl(64'h0090, large_directory, writeback, 1'b1, 3'd2);
      xl(64'h1098, upper_level, writeback, 1'b1, 3'd3);
      close_out();
   end

   initial begin
      repeat (2000) @(posedge core_clk_in);
      errors++;
      close_out();
   end
endmodule

// File: bench/walker_model.sv
// Walker model: issues translation requests to the typing block.
// Assumes the bench calls req; entry, address and range-type lines are scrambled between requests.
`timescale 1ns/100ps
module walker_model
   import attr_pkg::*;
#(
   parameter int ENTRY_W = 64,
   parameter int ADDR_W  = 52
) (
   // Clock
   input  wire logic               clk_in,
   // Request lines
   output logic                    valid_out,
   output logic [ENTRY_W-1:0]      entry_out,
   output entry_kind_e             kind_out,
   output logic [ADDR_W-1:0]       addr_out,
   output mem_type_e               range_type_out,
   output logic                    range_enable_out
);
   logic [ADDR_W-1:0] sent;

   initial begin
      valid_out = 1'b0;
      entry_out = '0;
      kind_out = leaf_entry;
      addr_out = '0;
      range_type_out = writeback;
      range_enable_out = 1'b1;
      sent = '0;
   end

   task automatic req(input logic [ENTRY_W-1:0] e, input entry_kind_e k, input mem_type_e r, input logic en);
      @(posedge clk_in);
      sent = sent + 'h1000;
      valid_out <= 1'b1;
      entry_out <= e;
      kind_out <= k;
      addr_out <= sent;
      range_type_out <= r;
      range_enable_out <= en;
      @(posedge clk_in);
      valid_out <= 1'b0;
      entry_out <= ~e;
      addr_out <= ~sent;
      range_type_out <= mem_type_e'(~r);
      #1;
   endtask
endmodule

// File: include/attr_pkg.sv
// Table layout, memory-type codes and entry bit positions for page typing.
// Assumes one core clock domain; imported by every typing file.
package attr_pkg;

   // Table register layout
   localparam int TABLE_W    = 64;
   localparam int SLOT_W     = 8;
   localparam int SLOT_COUNT = 8;
   localparam int CODE_W     = 3;
   localparam int INDEX_W    = 3;

   // Slots 0..3 and 4..7: writeback, writethrough, uncacheable minus, uncacheable
   localparam logic [63:0] TABLE_RESET = 64'h0007_0406_0007_0406;

   // Entry bit positions
   localparam int SEL_BIT_LEAF  = 7;
   localparam int SEL_BIT_LARGE = 12;
   localparam int CD_BIT        = 4;
   localparam int WT_BIT        = 3;

   // Slot and effective memory types; code 2 marks the cache-disabled result
   typedef enum logic [2:0] {
      uncacheable              = 3'h0,
      write_combining          = 3'h1,
      cache_disabled_effective = 3'h2,
      writethrough_type        = 3'h4,
      write_protect            = 3'h5,
      writeback                = 3'h6,
      uncacheable_minus        = 3'h7
   } mem_type_e;

   // Kind of entry supplied by the walker
   typedef enum logic [1:0] {
      leaf_entry      = 2'h0,
      large_directory = 2'h1,
      upper_level     = 2'h2
   } entry_kind_e;

endpackage

// File: include/typing_if.sv
// Signals shared by the typing core, the index extractor and the combiner.
// Assumes all users sit on the core clock; carries no state.
`timescale 1ns/100ps
interface typing_if #(
   parameter int ENTRY_W = 64
);
   import attr_pkg::*;

   logic [ENTRY_W-1:0] entry;
   entry_kind_e        kind;
   logic [INDEX_W-1:0] index;
   mem_type_e          slot_type;
   mem_type_e          range_type;
   logic               range_enable;
   mem_type_e          eff_type;

   modport index_side (input entry, input kind, output index);
   modport combine_side (input slot_type, input range_type, input range_enable, output eff_type);
endinterface

// File: logic/page_attribute_memory_typing.sv
// Page attribute table: eight memory-type slots, index selection and
// combination with the range type, plus per-access cache policy flags.
// Assumes the walker and cache logic share core_clk_in; no synchronisers.
`timescale 1ns/100ps
module page_attribute_memory_typing #(
   parameter int ENTRY_W = 64,
   parameter int ADDR_W  = 52
) (
   // Clock and reset
   input  wire logic                          core_clk_in,
   input  wire logic                          arst_n_in,
   // Table register path
   input  wire logic                          wr_valid_in,
   input  wire logic [attr_pkg::TABLE_W-1:0]  wr_data_in,
   input  wire logic                          rd_valid_in,
   output logic                               wr_done_out,
   output logic                               fault_out,
   output logic                               fault_reserved_out,
   output logic [attr_pkg::SLOT_COUNT-1:0]    fault_slots_out,
   output logic                               rd_done_out,
   output logic [attr_pkg::TABLE_W-1:0]       rd_data_out,
   // Translation walker
   input  wire logic                          xlate_valid_in,
   input  wire logic [ENTRY_W-1:0]            entry_in,
   input  wire attr_pkg::entry_kind_e         kind_in,
   input  wire logic [ADDR_W-1:0]             phys_addr_in,
   input  wire attr_pkg::mem_type_e           range_type_in,
   input  wire logic                          range_enable_in,
   // Cache and bus logic
   output logic                               typed_valid_out,
   output logic [ADDR_W-1:0]                  typed_addr_out,
   output logic [attr_pkg::INDEX_W-1:0]       slot_index_out,
   output attr_pkg::mem_type_e                slot_type_out,
   output attr_pkg::mem_type_e                eff_type_out,
   output logic                               read_alloc_out,
   output logic                               read_excl_ok_out,
   output logic                               write_alloc_out,
   output logic                               write_to_memory_out,
   output logic                               write_hit_update_out,
   output logic                               write_hit_inval_out,
   output logic                               combine_ok_out,
   output logic                               spec_ok_out
);
   import attr_pkg::*;

   if (ADDR_W < 12 || ADDR_W > 64) begin : g_check
      $error("ADDR_W out of range");
   end

   typing_if #(.ENTRY_W(ENTRY_W)) link ();

   logic [TABLE_W-1:0]    table_q;
   logic [SLOT_COUNT-1:0] rsvd_bad;
   logic [SLOT_COUNT-1:0] code_bad;
   logic                  wr_reject;
   logic                  next_read_alloc;
   logic                  next_read_excl;
   logic                  next_write_alloc;
   logic                  next_write_mem;
   logic                  next_hit_update;
   logic                  next_hit_inval;
   logic                  next_combine;
   logic                  next_spec;

   // Per-slot write checks
   for (genvar i = 0; i < SLOT_COUNT; i++) begin : g_slot
      assign rsvd_bad[i] = |wr_data_in[i*SLOT_W+CODE_W +: SLOT_W-CODE_W];
      // Codes 2 and 3 have bits 2:1 equal to 01
      assign code_bad[i] = (wr_data_in[i*SLOT_W+1 +: 2] == 2'h1);
   end

   assign wr_reject = (|rsvd_bad) | (|code_bad);

   // Table register
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         table_q <= TABLE_RESET;
      end else if (wr_valid_in && !wr_reject) begin
         table_q <= wr_data_in;
      end
   end

   // Write response
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wr_done_out        <= 1'b0;
         fault_out          <= 1'b0;
         fault_reserved_out <= 1'b0;
         fault_slots_out    <= '0;
      end else begin
         wr_done_out        <= wr_valid_in;
         fault_out          <= wr_valid_in && wr_reject;
         fault_reserved_out <= wr_valid_in && (|rsvd_bad);
         fault_slots_out    <= wr_valid_in ? (rsvd_bad | code_bad) : '0;
      end
   end

   // Read response
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rd_done_out <= 1'b0;
         rd_data_out <= '0;
      end else begin
         rd_done_out <= rd_valid_in;
         if (rd_valid_in) begin
            rd_data_out <= table_q;
         end
      end
   end

   // Indexing runs on every request with no bypass
   assign link.entry        = entry_in;
   assign link.kind         = kind_in;
   assign link.slot_type    = mem_type_e'(table_q[link.index*SLOT_W +: CODE_W]);
   assign link.range_type   = range_type_in;
   assign link.range_enable = range_enable_in;

   slot_index_extract #(
      .ENTRY_W (ENTRY_W)
   ) u_index (
      .link (link.index_side)
   );

   type_combine u_combine (
      .link (link.combine_side)
   );

   // Cache policy from the effective type
   always_comb begin
      next_read_alloc  = 1'b0;
      next_read_excl   = 1'b0;
      next_write_alloc = 1'b0;
      next_write_mem   = 1'b1;
      next_hit_update  = 1'b0;
      next_hit_inval   = 1'b0;
      next_combine     = 1'b0;
      next_spec        = 1'b0;
      unique case (link.eff_type)
         uncacheable, cache_disabled_effective: begin
            next_write_mem = 1'b1;
         end
         uncacheable_minus: begin
            next_write_mem = 1'b1;
         end
         write_combining: begin
            next_combine = 1'b1;
            next_spec    = 1'b1;
         end
         writethrough_type: begin
            next_read_alloc = 1'b1;
            next_hit_update = 1'b1;
            next_spec       = 1'b1;
         end
         write_protect: begin
            next_read_alloc = 1'b1;
            next_hit_inval  = 1'b1;
            next_spec       = 1'b1;
         end
         writeback: begin
            next_read_alloc  = 1'b1;
            next_read_excl   = 1'b1;
            next_write_alloc = 1'b1;
            next_write_mem   = 1'b0;
            next_hit_update  = 1'b1;
            next_spec        = 1'b1;
         end
         default: begin
            next_write_mem = 1'b1;
         end
      endcase
   end

   // Typed access result, one cycle after the request
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         typed_valid_out <= 1'b0;
         typed_addr_out  <= '0;
         slot_index_out  <= '0;
         slot_type_out   <= uncacheable;
         eff_type_out    <= uncacheable;
      end else begin
         typed_valid_out <= xlate_valid_in;
         if (xlate_valid_in) begin
            typed_addr_out <= phys_addr_in;
            slot_index_out <= link.index;
            slot_type_out  <= link.slot_type;
            eff_type_out   <= link.eff_type;
         end
      end
   end

   // Policy flags, held with the typed result
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         read_alloc_out       <= 1'b0;
         read_excl_ok_out     <= 1'b0;
         write_alloc_out      <= 1'b0;
         write_to_memory_out  <= 1'b0;
         write_hit_update_out <= 1'b0;
         write_hit_inval_out  <= 1'b0;
         combine_ok_out       <= 1'b0;
         spec_ok_out          <= 1'b0;
      end else if (xlate_valid_in) begin
         read_alloc_out       <= next_read_alloc;
         read_excl_ok_out     <= next_read_excl;
         write_alloc_out      <= next_write_alloc;
         write_to_memory_out  <= next_write_mem;
         write_hit_update_out <= next_hit_update;
         write_hit_inval_out  <= next_hit_inval;
         combine_ok_out       <= next_combine;
         spec_ok_out          <= next_spec;
      end
   end

   // Checks
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!arst_n_in);

   reserved_reject_a: assert property (
      wr_valid_in && (|rsvd_bad) |=> fault_out && fault_reserved_out && $stable(table_q))
      else $error("reserved bits write not rejected");

   code_reject_a: assert property (
      wr_valid_in && (|code_bad) |=> fault_out && $stable(table_q))
      else $error("unsupported code write not rejected");

   write_accept_a: assert property (
      wr_valid_in && !wr_reject |=> !fault_out && (table_q == $past(wr_data_in)))
      else $error("legal table write not stored");

   table_hold_a: assert property (
      !wr_valid_in |=> $stable(table_q))
      else $error("table changed without a write");

   leaf_index_a: assert property (
      xlate_valid_in && kind_in == leaf_entry
      |=> slot_index_out == {$past(entry_in[SEL_BIT_LEAF]), $past(entry_in[CD_BIT]), $past(entry_in[WT_BIT])})
      else $error("leaf index wrong");

   large_index_a: assert property (
      xlate_valid_in && kind_in == large_directory
      |=> slot_index_out == {$past(entry_in[SEL_BIT_LARGE]), $past(entry_in[CD_BIT]), $past(entry_in[WT_BIT])})
      else $error("large page index wrong");

   upper_index_a: assert property (
      xlate_valid_in && kind_in == upper_level |=> typed_valid_out && !slot_index_out[2])
      else $error("upper level used slots 4 to 7");

   minus_override_a: assert property (
      xlate_valid_in && range_enable_in && link.slot_type == uncacheable_minus
      && range_type_in == write_combining |=> eff_type_out == write_combining)
      else $error("uncacheable minus not overridden");

   uc_slot_a: assert property (
      xlate_valid_in && range_enable_in && link.slot_type == uncacheable
      && range_type_in != uncacheable |=> eff_type_out == cache_disabled_effective)
      else $error("uncacheable slot combine wrong");

   wt_slot_a: assert property (
      xlate_valid_in && range_enable_in && link.slot_type == writethrough_type
      && (range_type_in == write_combining || range_type_in == write_protect)
      |=> eff_type_out == cache_disabled_effective)
      else $error("writethrough slot combine wrong");

   range_off_a: assert property (
      xlate_valid_in && !range_enable_in && link.slot_type == writeback |=> eff_type_out == uncacheable)
      else $error("disabled range not uncacheable");

   no_cache_a: assert property (
      typed_valid_out && (eff_type_out == uncacheable || eff_type_out == cache_disabled_effective)
      |-> !read_alloc_out && !combine_ok_out && !spec_ok_out)
      else $error("uncacheable access allowed caching");

   wb_policy_a: assert property (
      typed_valid_out && eff_type_out == writeback |-> write_alloc_out && read_excl_ok_out)
      else $error("writeback policy wrong");

   wp_policy_a: assert property (
      typed_valid_out && eff_type_out == write_protect
      |-> write_hit_inval_out && write_to_memory_out && !write_alloc_out)
      else $error("write protect policy wrong");

   fault_write_c: cover property (wr_valid_in && wr_reject ##1 fault_out);
   good_write_c: cover property (wr_valid_in && !wr_reject ##1 wr_done_out ##1 xlate_valid_in);
   high_slot_c: cover property (xlate_valid_in && kind_in == leaf_entry && entry_in[SEL_BIT_LEAF]);
   wc_override_c: cover property (typed_valid_out && slot_type_out == uncacheable_minus
                                  && eff_type_out == write_combining);

endmodule

// File: logic/slot_index_extract.sv
// Forms the three-bit slot index from one translation-table entry.
// Assumes the walker presents the entry selected by the paging mode.
`timescale 1ns/100ps
module slot_index_extract #(
   parameter int ENTRY_W = 64
) (
   // Entry in, index out
   typing_if.index_side link
);
   import attr_pkg::*;

   logic select_bit;

   if (ENTRY_W <= SEL_BIT_LARGE) begin : g_check
      $error("ENTRY_W too narrow for the select bit");
   end

   always_comb begin
      unique case (link.kind)
         leaf_entry:      select_bit = link.entry[SEL_BIT_LEAF];
         large_directory: select_bit = link.entry[SEL_BIT_LARGE];
         upper_level:     select_bit = 1'b0;
         default:         select_bit = 1'b0;
      endcase
   end

   // Select bit high, then cache disable, then writethrough
   assign link.index = {select_bit, link.entry[CD_BIT], link.entry[WT_BIT]};

endmodule

// File: logic/type_combine.sv
// Combines the selected slot type with the range-register type.
// Assumes slot codes 2 and 3 never reach it; writes reject them.
`timescale 1ns/100ps
module type_combine (
   // Slot and range types in, effective type out
   typing_if.combine_side link
);
   import attr_pkg::*;

   always_comb begin
      mem_type_e range_t;
      range_t = link.range_enable ? link.range_type : uncacheable;
      unique case (link.slot_type)
         uncacheable: begin
            link.eff_type = (range_t == uncacheable) ? uncacheable : cache_disabled_effective;
         end
         uncacheable_minus: begin
            if (range_t == uncacheable || range_t == write_combining) begin
               link.eff_type = range_t;
            end else begin
               link.eff_type = cache_disabled_effective;
            end
         end
         write_combining: begin
            link.eff_type = write_combining;
         end
         write_protect: begin
            unique case (range_t)
               uncacheable:             link.eff_type = uncacheable;
               write_protect, writeback: link.eff_type = write_protect;
               default:                 link.eff_type = cache_disabled_effective;
            endcase
         end
         writethrough_type: begin
            unique case (range_t)
               uncacheable:                    link.eff_type = uncacheable;
               write_combining, write_protect: link.eff_type = cache_disabled_effective;
               default:                        link.eff_type = writethrough_type;
            endcase
         end
         writeback: begin
            link.eff_type = range_t;
         end
         default: begin
            link.eff_type = uncacheable;
         end
      endcase
   end

endmodule
